// ### ips_pkg.sv
// Constants, field positions and carrier types of the interrupt priority select block
`default_nettype none

package ips_pkg;

  // ==========================================================================
  // Priority levels (1 is highest, 18 lowest); vector index is level minus one
  // ==========================================================================
  localparam int unsigned LEVELS = 18;
  localparam logic [4:0] LVL_MC_DATA = 5'h01;
  localparam logic [4:0] LVL_DBG_ADDR = 5'h02;
  localparam logic [4:0] LVL_MC_INSTR = 5'h03;
  localparam logic [4:0] LVL_DBG_ASYNC = 5'h04;
  localparam logic [4:0] LVL_CRIT_IN = 5'h05;
  localparam logic [4:0] LVL_WATCHDOG = 5'h06;
  localparam logic [4:0] LVL_ITLB_MISS = 5'h07;
  localparam logic [4:0] LVL_ISTOR_ZONE = 5'h08;
  localparam logic [4:0] LVL_ISTOR_PAGE = 5'h09;
  localparam logic [4:0] LVL_PROG_SYSCALL = 5'h0A;
  localparam logic [4:0] LVL_DTLB_MISS = 5'h0B;
  localparam logic [4:0] LVL_DSTOR_ZONE = 5'h0C;
  localparam logic [4:0] LVL_DSTOR_WRITE = 5'h0D;
  localparam logic [4:0] LVL_ALIGN = 5'h0E;
  localparam logic [4:0] LVL_DBG_SYNC = 5'h0F;
  localparam logic [4:0] LVL_EXT = 5'h10;
  localparam logic [4:0] LVL_FIXED_TMR = 5'h11;
  localparam logic [4:0] LVL_PROG_TMR = 5'h12;
  localparam logic [4:0] LVL_NONE = 5'h00;

  // Levels served through the critical save/restore pair (1..6 and 15)
  localparam logic [17:0] CRIT_LEVEL_MASK = 18'h0403F;

  // ==========================================================================
  // Persistent status bits, also the order of the unmask vector
  // ==========================================================================
  localparam int unsigned PERSIST_N = 7;
  localparam int unsigned PS_MC_DATA = 0;
  localparam int unsigned PS_DBG_ASYNC = 1;
  localparam int unsigned PS_CRIT_IN = 2;
  localparam int unsigned PS_WATCHDOG = 3;
  localparam int unsigned PS_EXT = 4;
  localparam int unsigned PS_FIXED_TMR = 5;
  localparam int unsigned PS_PROG_TMR = 6;

  localparam logic [1:0] ZONE_NO_ACCESS = 2'h0;
  localparam logic [6:0] RESET_STATUS = 7'h00;
  localparam logic [31:0] RESET_ADDR = 32'h0000_0000;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic exec_attempt;
    logic instr_xlate_on;
    logic instr_user_mode;
    logic [1:0] instr_zone;
    logic page_execute_permit;
    logic instr_page_guarded_attr;
    logic instr_tlb_miss;
    logic instr_bus_error;
    logic illegal_instr;
    logic trap_instr;
    logic priv_in_problem;
    logic system_call_instr;
    logic data_access;
    logic data_write;
    logic data_xlate_on;
    logic data_user_mode;
    logic [1:0] data_zone;
    logic page_write_permit;
    logic page_user_attr_zero;
    logic storage_user_attr_reg;
    logic data_tlb_miss;
    logic zero_block_uncached;
    logic misaligned_cache_read;
    logic misaligned_load_reserve_instr;
    logic misaligned_store_cond;
  } ips_sync_s;

  typedef struct packed {
    logic instr_addr_compare_event;
    logic exception_debug_event;
    logic unconditional_debug_event;
    logic branch_taken_event;
    logic data_addr_compare_event;
    logic data_value_compare_event;
    logic instr_complete_event;
    logic trap_taken_event;
  } ips_debug_s;

  typedef struct packed {
    logic data_bus_error;
    logic crit_input_level;
    logic watchdog_first_timeout;
    logic ext_input_level;
    logic fixed_interval_timer;
    logic programmable_interval_timer;
  } ips_async_s;

  typedef struct packed {
    logic valid;
    logic critical;
    logic [4:0] level;
    logic [17:0] cause;
  } ips_grant_s;

endpackage : ips_pkg

`default_nettype wire

// ### ips_select.sv
// Interrupt priority selection with persistent masked-exception status
`default_nettype none

module ips_select
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ips_pkg::ips_sync_s sync_req,
  input wire ips_pkg::ips_debug_s debug_req,
  input wire ips_pkg::ips_async_s async_req,
  input wire logic internal_debug_mode,
  input wire logic debug_enable,
  input wire logic [6:0] unmask,
  input wire logic [6:0] status_clear,
  input wire logic take_ack,
  input wire logic [31:0] return_addr,
  output ips_pkg::ips_grant_s grant,
  output logic [6:0] status,
  output logic noncrit_save_strobe,
  output logic crit_save_strobe,
  output logic [31:0] noncrit_return_addr_reg,
  output logic [31:0] crit_return_addr_reg
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Lowest index set wins; index 0 is level 1
  function automatic logic [17:0] pick_first(input logic [17:0] vec);
    logic [17:0] hit;
    logic found;
    hit = 18'h00000;
    found = 1'b0;
    for (int i = 0; i < 18; i++)
    begin
      if (vec[i] && !found)
      begin
        hit[i] = 1'b1;
        found = 1'b1;
      end
    end
    return hit;
  endfunction

  // One-hot to level number, zero when nothing set
  function automatic logic [4:0] level_of(input logic [17:0] onehot);
    logic [4:0] lvl;
    lvl = ips_pkg::LVL_NONE;
    for (int i = 0; i < 18; i++)
    begin
      if (onehot[i])
      begin
        lvl = 5'(i + 1);
      end
    end
    return lvl;
  endfunction

  // ==========================================================================
  // Persistent status of maskable asynchronous sources
  // ==========================================================================
  logic [6:0] event_in; // Raw events feeding status bits
  logic [6:0] raise; // Status bits allowed through their mask

  // Event order follows the PS_ indices
  assign event_in[ips_pkg::PS_MC_DATA] = async_req.data_bus_error;
  assign event_in[ips_pkg::PS_DBG_ASYNC] = internal_debug_mode &&
    (debug_req.exception_debug_event || debug_req.unconditional_debug_event);
  assign event_in[ips_pkg::PS_CRIT_IN] = async_req.crit_input_level;
  assign event_in[ips_pkg::PS_WATCHDOG] = async_req.watchdog_first_timeout;
  assign event_in[ips_pkg::PS_EXT] = async_req.ext_input_level;
  assign event_in[ips_pkg::PS_FIXED_TMR] = async_req.fixed_interval_timer;
  assign event_in[ips_pkg::PS_PROG_TMR] = async_req.programmable_interval_timer;

  genvar g;
  generate
    for (g = 0; g < 7; g++)
    begin : g_status
      // Sticky bit; a new event beats a clear in the same cycle
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          status[g] <= ips_pkg::RESET_STATUS[g];
        end
        else if (event_in[g])
        begin
          status[g] <= 1'b1;
        end
        else if (status_clear[g])
        begin
          status[g] <= 1'b0;
        end
      end
      // Raised only while unmasked; unmasking later releases kept status
      assign raise[g] = status[g] && unmask[g];
    end
  endgenerate

  // ==========================================================================
  // Cause decoding into the eighteen-level request vector
  // ==========================================================================
  logic [17:0] pend; // Pending and enabled, index = level - 1
  logic dbg_ok; // Debug interrupts allowed
  logic istor_ok; // Instruction translation check applies
  logic dstor_ok; // Data translation check applies

  // Debug interrupts only exist in internal debug mode; debug enable masks them
  assign dbg_ok = internal_debug_mode && debug_enable;
  assign istor_ok = sync_req.instr_xlate_on && sync_req.exec_attempt;
  assign dstor_ok = sync_req.data_xlate_on && sync_req.data_access;

  always_comb
  begin
    pend = 18'h00000;
    // Critical group
    pend[0] = raise[ips_pkg::PS_MC_DATA];
    pend[1] = dbg_ok && debug_req.instr_addr_compare_event;
    // Fetch error only matters once execution is attempted
    pend[2] = unmask[ips_pkg::PS_MC_DATA] && sync_req.exec_attempt &&
      sync_req.instr_bus_error;
    pend[3] = debug_enable && raise[ips_pkg::PS_DBG_ASYNC];
    pend[4] = raise[ips_pkg::PS_CRIT_IN];
    pend[5] = raise[ips_pkg::PS_WATCHDOG];
    // Noncritical instruction side
    pend[6] = sync_req.exec_attempt && sync_req.instr_tlb_miss;
    pend[7] = istor_ok && sync_req.instr_user_mode &&
      (sync_req.instr_zone == ips_pkg::ZONE_NO_ACCESS);
    pend[8] = istor_ok && (!sync_req.page_execute_permit ||
      sync_req.instr_page_guarded_attr);
    pend[9] = sync_req.illegal_instr || sync_req.trap_instr ||
      sync_req.priv_in_problem || sync_req.system_call_instr;
    // Data side, noncritical except synchronous debug at level 15
    pend[10] = sync_req.data_access && sync_req.data_tlb_miss;
    pend[11] = dstor_ok && sync_req.data_user_mode &&
      (sync_req.data_zone == ips_pkg::ZONE_NO_ACCESS);
    pend[12] = dstor_ok && sync_req.data_write && (!sync_req.page_write_permit ||
      sync_req.page_user_attr_zero || sync_req.storage_user_attr_reg);
    pend[13] = sync_req.zero_block_uncached || sync_req.misaligned_cache_read ||
      sync_req.misaligned_load_reserve_instr || sync_req.misaligned_store_cond;
    pend[14] = dbg_ok && (debug_req.branch_taken_event ||
      debug_req.data_addr_compare_event || debug_req.data_value_compare_event ||
      debug_req.instr_complete_event || debug_req.trap_taken_event);
    // Asynchronous noncritical tail
    pend[15] = raise[ips_pkg::PS_EXT];
    pend[16] = raise[ips_pkg::PS_FIXED_TMR];
    pend[17] = raise[ips_pkg::PS_PROG_TMR];
  end

  // ==========================================================================
  // Selection
  // ==========================================================================
  logic [17:0] next_cause; // Single winner this cycle

  // Fixed order serialises competing requests, whatever their class
  assign next_cause = pick_first(pend);

  // Registered grant; one cycle from request to presentation
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      grant <= '0;
    end
    else
    begin
      grant.valid <= |pend;
      grant.critical <= |(next_cause & ips_pkg::CRIT_LEVEL_MASK);
      grant.level <= level_of(next_cause);
      grant.cause <= next_cause;
    end
  end

  // ==========================================================================
  // Return address capture on acceptance
  // ==========================================================================
  logic take_crit; // Critical grant accepted
  logic take_noncrit; // Noncritical grant accepted

  // An ack with nothing presented is ignored
  assign take_crit = take_ack && grant.valid && grant.critical;
  assign take_noncrit = take_ack && grant.valid && !grant.critical;

  // Save strobes pulse for one cycle after acceptance
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      noncrit_save_strobe <= 1'b0;
      crit_save_strobe <= 1'b0;
    end
    else
    begin
      noncrit_save_strobe <= take_noncrit;
      crit_save_strobe <= take_crit;
    end
  end

  // Noncritical return address register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      noncrit_return_addr_reg <= ips_pkg::RESET_ADDR;
    end
    else if (take_noncrit)
    begin
      noncrit_return_addr_reg <= return_addr;
    end
  end

  // Critical return address register; kept apart so a critical
  // interrupt inside a noncritical handler does not lose its return
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      crit_return_addr_reg <= ips_pkg::RESET_ADDR;
    end
    else if (take_crit)
    begin
      crit_return_addr_reg <= return_addr;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Selection: one winner, class taken from the winner
  chk_one_grant: assert property ($onehot0(grant.cause))
    else $error("more than one interrupt granted");

  chk_class_match: assert property (grant.valid |->
    (grant.critical == |(grant.cause & ips_pkg::CRIT_LEVEL_MASK)))
    else $error("grant class does not match cause");

  chk_one_strobe: assert property (!(crit_save_strobe && noncrit_save_strobe))
    else $error("both save strobes raised together");

  // Persistent status: masked events are kept, unmasking releases them
  // A clear in the same cycle must lose, or a late event would vanish
  chk_event_sticks: assert property (event_in != 7'h00 |=>
    (status & $past(event_in)) == $past(event_in))
    else $error("event did not set its status bit");

  chk_masked_kept: assert property (async_req.ext_input_level &&
    !unmask[ips_pkg::PS_EXT] ##1 !unmask[ips_pkg::PS_EXT] |->
    status[ips_pkg::PS_EXT] ##1 !grant.cause[15])
    else $error("masked external event not kept or raised");

  chk_unmask_raise: assert property (status[ips_pkg::PS_PROG_TMR] &&
    unmask[ips_pkg::PS_PROG_TMR] && pend[16:0] == 17'h00000 |=>
    grant.level == ips_pkg::LVL_PROG_TMR)
    else $error("unmasked kept timer status not raised");

  chk_clear_cancel: assert property (status_clear[ips_pkg::PS_FIXED_TMR] &&
    !async_req.fixed_interval_timer |=> !status[ips_pkg::PS_FIXED_TMR])
    else $error("status clear did not cancel");

  chk_mask_quiet: assert property (!unmask[ips_pkg::PS_CRIT_IN] |=>
    !grant.cause[4])
    else $error("masked critical input granted");

  // Fixed order: each level holds against everything below it
  chk_top_level: assert property (pend[0] |=>
    grant.level == ips_pkg::LVL_MC_DATA && grant.critical)
    else $error("data machine check not first");

  chk_debug_gate: assert property (!internal_debug_mode |=>
    !grant.cause[1] && !grant.cause[14])
    else $error("synchronous debug granted outside debug mode");

  chk_watchdog_level: assert property (pend[5] && pend[4:0] == 5'h00 |=>
    grant.level == ips_pkg::LVL_WATCHDOG && grant.critical)
    else $error("watchdog not granted at its level");

  chk_itlb_level: assert property (pend[6] && pend[5:0] == 6'h00 |=>
    grant.level == ips_pkg::LVL_ITLB_MISS && !grant.critical)
    else $error("instruction TLB miss not granted at its level");

  chk_sync_debug_level: assert property (pend[14] && pend[13:0] == 14'h0000 |=>
    grant.level == ips_pkg::LVL_DBG_SYNC && grant.critical)
    else $error("synchronous debug not granted at its level");

  chk_last_level: assert property (grant.level == ips_pkg::LVL_PROG_TMR |->
    $past(pend[16:0]) == 17'h00000)
    else $error("timer granted over higher request");

  chk_pick_level: assert property (|pend |=> grant.valid &&
    grant.level == level_of($past(pick_first(pend))))
    else $error("grant is not the highest pending level");

  // Acceptance: address goes to the register of the granted class
  chk_save_route: assert property (take_crit |=> crit_save_strobe &&
    !noncrit_save_strobe && crit_return_addr_reg == $past(return_addr))
    else $error("critical return address not saved");

  chk_noncrit_route: assert property (take_noncrit |=> noncrit_save_strobe &&
    !crit_save_strobe && noncrit_return_addr_reg == $past(return_addr))
    else $error("noncritical return address not saved");

  // Main scenarios
  cov_two_pending: cover property (pend[0] && pend[17]);
  cov_unmask: cover property ($rose(unmask[ips_pkg::PS_EXT]) && status[ips_pkg::PS_EXT]);
  cov_crit_take: cover property (take_crit);
  cov_noncrit_take: cover property (take_noncrit);
  cov_set_wins: cover property (event_in[ips_pkg::PS_FIXED_TMR] &&
    status_clear[ips_pkg::PS_FIXED_TMR]);

endmodule // ips_select

`default_nettype wire

// ### ips_core_model.sv
// Behavioural pipeline that accepts grants and supplies return addresses
`default_nettype none

module ips_core_model
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ack_en,
  input wire ips_pkg::ips_grant_s grant,
  output logic take_ack,
  output logic [31:0] return_addr,
  output logic [31:0] sent_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  logic ack_q; // Bench request seen at the rising edge

  // ======
  // Request sampling and record of the address handed over
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      sent_addr <= 32'h0;
    end
    else
    begin
      ack_q <= ack_en;
      // Same edge the block takes the acceptance
      if (take_ack && grant.valid)
      begin
        sent_addr <= return_addr;
      end
    end
  end

  // ======
  // Driven off the falling edge; the address walks every cycle so a stale capture shows
  always @(negedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      take_ack <= 1'b0;
      return_addr <= 32'h1234_5678;
    end
    else
    begin
      // Only accept a grant that is really presented
      take_ack <= ack_q && grant.valid;
      return_addr <= {return_addr[30:0], ~return_addr[31]};
    end
  end
endmodule // ips_core_model

`default_nettype wire

// ### interrupt_priority_select_tb_top.sv
// Self-checking bench for the interrupt priority select block
`default_nettype none

module interrupt_priority_select_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ======
  // Stimulus and observed signals
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  ips_pkg::ips_sync_s s; // Pipeline causes
  ips_pkg::ips_debug_s d; // Debug events
  ips_pkg::ips_async_s a; // Async sources
  logic idm = 1'b1; // Internal debug mode
  logic dbe = 1'b1; // Debug interrupts unmasked
  logic [6:0] unm = 7'h7F;
  logic [6:0] sclr = 7'h00;
  logic ack_en = 1'b0;
  logic tack;
  logic [31:0] raddr;
  logic [31:0] sent; // Address the core handed over
  ips_pkg::ips_grant_s g;
  logic [6:0] st;
  logic nstb;
  logic cstb;
  logic [31:0] nreg;
  logic [31:0] creg;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int pl[7] = '{1, 4, 5, 6, 16, 17, 18}; // Level of each sticky bit

  always #12.5 clk_sys = ~clk_sys;

  ips_select DUT
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .sync_req(s),
    .debug_req(d),
    .async_req(a),
    .internal_debug_mode(idm),
    .debug_enable(dbe),
    .unmask(unm),
    .status_clear(sclr),
    .take_ack(tack),
    .return_addr(raddr),
    .grant(g),
    .status(st),
    .noncrit_save_strobe(nstb),
    .crit_save_strobe(cstb),
    .noncrit_return_addr_reg(nreg),
    .crit_return_addr_reg(creg)
  );

  ips_core_model core
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ack_en(ack_en),
    .grant(g),
    .take_ack(tack),
    .return_addr(raddr),
    .sent_addr(sent)
  );

  // ======
  // Shared helpers
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Quiet sources; permits set so no storage cause fires by accident
  task automatic base();
    s = '0;
    s.exec_attempt = 1'b1;
    s.instr_xlate_on = 1'b1;
    s.instr_user_mode = 1'b1;
    s.instr_zone = 2'h1;
    s.page_execute_permit = 1'b1;
    s.data_access = 1'b1;
    s.data_write = 1'b1;
    s.data_xlate_on = 1'b1;
    s.data_user_mode = 1'b1;
    s.data_zone = 2'h1;
    s.page_write_permit = 1'b1;
    d = '0;
    a = '0;
  endtask

  // Sources dropped first, then sticky bits wiped
  task automatic clr_all();
    base();
    sclr = 7'h7F;
    tick(1);
    sclr = 7'h00;
    tick(2);
  endtask

  // One cause per priority level
  task automatic set_src(input int lvl, input logic v);
    case (lvl)
      1: a.data_bus_error = v;
      2: d.instr_addr_compare_event = v;
      3: s.instr_bus_error = v;
      4: d.exception_debug_event = v;
      5: a.crit_input_level = v;
      6: a.watchdog_first_timeout = v;
      7: s.instr_tlb_miss = v;
      8: s.instr_zone = v ? 2'h0 : 2'h1;
      9: s.page_execute_permit = !v;
      10: s.system_call_instr = v;
      11: s.data_tlb_miss = v;
      12: s.data_zone = v ? 2'h0 : 2'h1;
      13: s.page_write_permit = !v;
      14: s.zero_block_uncached = v;
      15: d.data_value_compare_event = v;
      16: a.ext_input_level = v;
      17: a.fixed_interval_timer = v;
      default: a.programmable_interval_timer = v;
    endcase
  endtask

  // Class follows the level: 1..6 and 15 are critical
  task automatic chk_grant(input int lvl);
    check("valid", 32'(g.valid), 32'h1);
    check("level", 32'(g.level), 32'(lvl));
    check("class", 32'(g.critical), 32'(lvl <= 6 || lvl == 15));
    check("cause", 32'(g.cause), 32'h1 << (lvl - 1));
  endtask

  // ======
  // Scenarios
  task automatic t_single();
    for (int l = 1; l <= 18; l++)
    begin
      clr_all();
      set_src(l, 1'b1);
      tick(3);
      chk_grant(l);
    end
  endtask

  // Everything from level k downward pending: k must win
  task automatic t_prio();
    for (int k = 1; k <= 18; k++)
    begin
      clr_all();
      for (int j = k; j <= 18; j++)
        set_src(j, 1'b1);
      tick(3);
      chk_grant(k);
    end
  endtask

  // Masked event sticks, unmask raises it, clearing first cancels it
  task automatic t_mask();
    for (int i = 0; i < 7; i++)
    begin
      clr_all();
      unm = 7'h00;
      set_src(pl[i], 1'b1);
      tick(1);
      set_src(pl[i], 1'b0);
      tick(2);
      check("sticky", 32'(st), 32'h1 << i);
      check("held", 32'(g.valid), 32'h0);
      unm[i] = 1'b1;
      tick(2);
      chk_grant(pl[i]);
      unm = 7'h00;
      sclr[i] = 1'b1;
      tick(1);
      sclr = 7'h00;
      unm[i] = 1'b1;
      tick(2);
      check("cancel", 32'(g.valid), 32'h0);
      unm = 7'h7F;
    end
  endtask

  // Debug causes need debug mode and the debug unmask
  task automatic t_dbg();
    clr_all();
    idm = 1'b0;
    set_src(2, 1'b1);
    set_src(4, 1'b1);
    set_src(15, 1'b1);
    tick(3);
    check("dbg off", 32'(g.valid), 32'h0);
    check("dbg st", 32'(st), 32'h0);
    set_src(4, 1'b0);
    idm = 1'b1;
    dbe = 1'b0;
    tick(3);
    check("dbg mask", 32'(g.valid), 32'h0);
    dbe = 1'b1;
    tick(2);
    chk_grant(2);
    set_src(2, 1'b0);
    tick(2);
    chk_grant(15);
  endtask

  // Alternative causes sharing a level; each alone must reach it
  task automatic t_alt();
    int lv[14] = '{4, 9, 10, 10, 10, 13, 13, 14, 14, 14, 15, 15, 15, 15};
    for (int n = 0; n < 14; n++)
    begin
      clr_all();
      case (n)
        0: d.unconditional_debug_event = 1'b1;
        1: s.instr_page_guarded_attr = 1'b1;
        2: s.illegal_instr = 1'b1;
        3: s.trap_instr = 1'b1;
        4: s.priv_in_problem = 1'b1;
        5: s.page_user_attr_zero = 1'b1;
        6: s.storage_user_attr_reg = 1'b1;
        7: s.misaligned_cache_read = 1'b1;
        8: s.misaligned_load_reserve_instr = 1'b1;
        9: s.misaligned_store_cond = 1'b1;
        10: d.branch_taken_event = 1'b1;
        11: d.data_addr_compare_event = 1'b1;
        12: d.instr_complete_event = 1'b1;
        default: d.trap_taken_event = 1'b1;
      endcase
      tick(3);
      chk_grant(lv[n]);
    end
  endtask

  // Event and clear in one cycle: the event wins; fetch error obeys its mask
  task automatic t_race();
    clr_all();
    unm = 7'h00;
    set_src(17, 1'b1);
    sclr = 7'h7F;
    tick(1);
    set_src(17, 1'b0);
    sclr = 7'h00;
    tick(1);
    check("set wins", 32'(st), 32'h20);
    set_src(3, 1'b1);
    tick(2);
    check("mc mask", 32'(g.valid), 32'h0);
    unm = 7'h7F;
    tick(2);
    chk_grant(3);
  endtask

  // One acceptance; strobe of the granted class for one cycle
  task automatic do_ack(input logic c);
    logic [31:0] other;
    other = c ? nreg : creg;
    ack_en = 1'b1;
    tick(1);
    ack_en = 1'b0;
    tick(1);
    check("strobe", 32'({cstb, nstb}), c ? 32'h2 : 32'h1);
    check("saved", c ? creg : nreg, sent);
    check("kept", c ? nreg : creg, other);
    tick(1);
    check("pulse", 32'({cstb, nstb}), 32'h0);
  endtask

  task automatic t_ack();
    clr_all();
    set_src(5, 1'b1);
    set_src(16, 1'b1);
    tick(3);
    do_ack(1'b1);
    set_src(5, 1'b0);
    sclr[2] = 1'b1;
    tick(1);
    sclr = 7'h00;
    tick(2);
    do_ack(1'b0);
  endtask

  // ======
  // Main sequence and hang guard
  initial
  begin
    base();
    tick(20);
    rst_n = 1'b1;
    tick(1);
    check("reset", 32'(g), 32'h0);
    t_single();
    t_prio();
    t_mask();
    t_dbg();
    t_alt();
    t_race();
    t_ack();
    tally_and_finish();
  end

  // Whole run is well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
endmodule // interrupt_priority_select_tb_top

`default_nettype wire
